// file: rtl/srel_defs.vh
`ifndef SREL_DEFS_VH
`define SREL_DEFS_VH

// status byte and mask width
`define SREL_W          8
// status byte position of the master summary / request for service bit
`define SREL_MSS_BIT    6
// status byte position of the standard event summary bit
`define SREL_ESB_BIT    5
// mask value after a power-on clear
`define SREL_MASK_RST   8'h00
// all-zero byte, used to detect an empty mask
`define SREL_ZERO       8'h00
// reset synchroniser idle value
`define SREL_SYNC_RST   2'h0
// summary position cleared out of the mask before use
`define SREL_MSS_HOLE   8'hBF

`endif

// file: rtl/srel_summary.v
`timescale 1ns/1ps
`include "srel_defs.vh"

// masked or of a bit vector: one and-term per bit, then a reduction
module srel_summary #(
   parameter W = `SREL_W
) (
   input  wire [W-1:0] value,
   input  wire [W-1:0] enable,
   output wire         result
);

   wire [W-1:0] term;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_term
         assign term[i] = value[i] & enable[i];
      end
   endgenerate

   assign result = |term;

endmodule

// file: rtl/srel_top.v
`timescale 1ns/1ps
`include "srel_defs.vh"

module srel_top #(
   parameter W = `SREL_W
) (
   input  wire         CLK,
   input  wire         NRST,
   input  wire         PSC_FLAG,
   input  wire [W-1:0] STB_IN,
   input  wire [W-1:0] STD_EVENT,
   input  wire [W-1:0] STD_EVENT_EN,
   input  wire         SRE_WR,
   input  wire [W-1:0] SRE_WDATA,
   input  wire         SRE_RD,
   input  wire         STB_RD,
   input  wire         SPOLL,
   input  wire         INST_RST,
   input  wire         RECALL,
   output reg  [W-1:0] SRE_RDATA,
   output reg          SRE_RVALID,
   output reg  [W-1:0] STB_DATA,
   output reg          STB_VALID,
   output reg  [W-1:0] SPOLL_DATA,
   output reg          SPOLL_VALID,
   output reg          CMD_DONE,
   output reg          MSS,
   output reg          SRQ
);

   reg  [1:0]   rst_sync_q;
   wire         rst_n;
   reg          por_pend_q;
   reg  [W-1:0] mask_q;
   reg  [W-1:0] mask_d;
   reg          mss_q;
   reg          rqs_q;
   reg          rqs_d;
   wire         esb;
   wire         mss;
   wire         mss_rise;
   wire         mask_zero;
   wire [W-1:0] mask_eff;
   reg  [W-1:0] stb_base;
   reg  [2:0]   psc_sync_q;
   reg          psc_q;
   reg          psc_d;
   reg  [W-1:0] mask_live;

   // reset released through two flops, asserted at once
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync_q <= `SREL_SYNC_RST;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // one cycle after release the power-on clear decision is taken
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         por_pend_q <= 1'b1;
      end else begin
         por_pend_q <= 1'b0;
      end
   end

   // clear flag comes from the settings store, outside this clock; no reset
   // on these flops so the level is settled before the power-on cycle
   always @(posedge CLK) begin
      psc_sync_q <= {psc_sync_q[1:0], PSC_FLAG};
   end

   always @* begin
      psc_d = psc_q;
      if (psc_sync_q[2] == psc_sync_q[1]) begin
         psc_d = psc_sync_q[2];
      end
   end

   always @(posedge CLK) begin
      psc_q <= psc_d;
   end

   // mask carries no async reset so it can survive a power cycle when the
   // clear flag is zero; until first written it is then undefined
   always @* begin
      mask_d = mask_q;
      if (!rst_n) begin
         mask_d = mask_q;
      end else if (por_pend_q) begin
         if (psc_q) begin
            mask_d = `SREL_MASK_RST;
         end
      end else if (SRE_WR) begin
         mask_d = SRE_WDATA;
      end
      // reset and recall strobes deliberately have no term here
   end

   always @(posedge CLK) begin
      mask_q <= mask_d;
   end

   // a mask about to be cleared at power on must not raise a request
   // in the clearing cycle itself
   always @* begin
      mask_live = mask_q;
      if (por_pend_q && psc_q) begin
         mask_live = `SREL_MASK_RST;
      end
   end

   // summary position itself never feeds the summary, avoiding a loop
   assign mask_eff  = mask_live & `SREL_MSS_HOLE;
   assign mask_zero = (mask_live == `SREL_ZERO);

   srel_summary #(
      .W (W)
   ) u_esb (
      .value  (STD_EVENT),
      .enable (STD_EVENT_EN),
      .result (esb)
   );

   always @* begin
      stb_base = STB_IN;
      stb_base[`SREL_ESB_BIT] = esb;
      stb_base[`SREL_MSS_BIT] = 1'b0;
   end

   srel_summary #(
      .W (W)
   ) u_mss (
      .value  (stb_base),
      .enable (mask_eff),
      .result (mss)
   );

   assign mss_rise = mss & ~mss_q;

   // a rise in the poll cycle wins, so a fresh request is never lost
   always @* begin
      rqs_d = rqs_q;
      if (mask_zero) begin
         rqs_d = 1'b0;
      end else if (mss_rise) begin
         rqs_d = 1'b1;
      end else if (SPOLL) begin
         rqs_d = 1'b0;
      end
   end

   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         mss_q <= 1'b0;
         rqs_q <= 1'b0;
         MSS   <= 1'b0;
         SRQ   <= 1'b0;
      end else begin
         mss_q <= mss;
         rqs_q <= rqs_d;
         MSS   <= mss;
         SRQ   <= rqs_d;
      end
   end

   // mask side: query reply and command acknowledge, nothing is cleared
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         SRE_RDATA  <= `SREL_ZERO;
         SRE_RVALID <= 1'b0;
         CMD_DONE   <= 1'b0;
      end else begin
         SRE_RVALID <= SRE_RD & ~por_pend_q;
         CMD_DONE   <= (SRE_WR | INST_RST | RECALL) & ~por_pend_q;
         if (SRE_RD) begin
            SRE_RDATA <= mask_q;
         end
      end
   end

   // status byte query answers one cycle after the strobe
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         STB_DATA  <= `SREL_ZERO;
         STB_VALID <= 1'b0;
      end else begin
         STB_VALID <= STB_RD & ~por_pend_q;
         if (STB_RD) begin
            STB_DATA <= stb_base | ({{(W-1){1'b0}}, mss} << `SREL_MSS_BIT);
         end
      end
   end

   // serial poll reply
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         SPOLL_DATA  <= `SREL_ZERO;
         SPOLL_VALID <= 1'b0;
      end else begin
         SPOLL_VALID <= SPOLL & ~por_pend_q;
         if (SPOLL) begin
            // poll returns the request bit as it stood before this poll
            SPOLL_DATA <= stb_base | ({{(W-1){1'b0}}, rqs_q} << `SREL_MSS_BIT);
         end
      end
   end

endmodule

// file: sim/srel_top_properties.sv
`timescale 1ns/1ps
module srel_chk (
   input wire       CLK, NRST, SRE_WR, SRE_RD, STB_RD, SPOLL, INST_RST, RECALL,
   input wire       SRE_RVALID, STB_VALID, SPOLL_VALID, CMD_DONE, MSS, SRQ,
   input wire [7:0] SPOLL_DATA
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   wr_ack_a: assert property (SRE_WR |=> CMD_DONE) else $error("no write ack");
   rd_ack_a: assert property (SRE_RD |=> SRE_RVALID) else $error("no mask reply");
   stb_ack_a: assert property (STB_RD |=> STB_VALID) else $error("no status reply");
   poll_clr_a: assert property (SPOLL |=> !SRQ || $rose(MSS)) else $error("poll kept srq");
   poll_bit_a: assert property (SPOLL |=> SPOLL_VALID && SPOLL_DATA[6] == $past(SRQ))
      else $error("poll byte wrong");
   rqs_set_a: assert property ($rose(MSS) |-> SRQ) else $error("summary rise no srq");
   read_keep_a: assert property (STB_RD && SRQ && !SPOLL && !SRE_WR |=> SRQ)
      else $error("read cleared srq");
   cmd_keep_a: assert property ((INST_RST || RECALL) && SRQ && !SPOLL && !SRE_WR
      |=> CMD_DONE && SRQ) else $error("reset or recall hit mask");
   cover property (SPOLL && SRQ);
   cover property ($rose(MSS));
   cover property (RECALL);
endmodule
bind srel_top srel_chk i_chk (.CLK(CLK), .NRST(NRST), .SRE_WR(SRE_WR), .SRE_RD(SRE_RD),
   .STB_RD(STB_RD), .SPOLL(SPOLL), .INST_RST(INST_RST), .RECALL(RECALL),
   .SRE_RVALID(SRE_RVALID), .STB_VALID(STB_VALID), .SPOLL_VALID(SPOLL_VALID),
   .CMD_DONE(CMD_DONE), .MSS(MSS), .SRQ(SRQ), .SPOLL_DATA(SPOLL_DATA));

// file: sim/srel_ctl.sv
`timescale 1ns/1ps
module srel_ctl (
   input  wire       clk,
   output reg  [5:0] cmd,
   output reg  [7:0] wd
);
   initial cmd = 6'h00;
   initial wd = 8'h00;
   // one command per call; data driven inverted once released
   task pulse(input [5:0] s, input [7:0] d);
      begin
         @(negedge clk);
         cmd = s;
         wd = d;
         @(negedge clk);
         cmd = 6'h00;
         wd = ~d;
      end
   endtask
endmodule

// file: sim/service_request_enable_logic_test.sv
`timescale 1ns/1ps
module service_request_enable_logic_test;
   reg         CLK = 0, NRST = 0, PSC = 1;
   reg  [7:0]  stb = 8'h00, ev = 8'h00, en = 8'h00;
   wire [5:0]  c;
   wire [7:0]  wd, sd, td, pd;
   wire        sv, tv, pv, cd, mss, srq;
   integer     failures = 0, samples_checked = 0;
   always #50 CLK = ~CLK;
   srel_ctl i_ctl (.clk(CLK), .cmd(c), .wd(wd));
   srel_top i_dut (.CLK(CLK), .NRST(NRST), .PSC_FLAG(PSC), .STB_IN(stb), .STD_EVENT(ev),
      .STD_EVENT_EN(en), .SRE_WR(c[5]), .SRE_WDATA(wd), .SRE_RD(c[4]), .STB_RD(c[3]),
      .SPOLL(c[2]), .INST_RST(c[1]), .RECALL(c[0]), .SRE_RDATA(sd), .SRE_RVALID(sv),
      .STB_DATA(td), .STB_VALID(tv), .SPOLL_DATA(pd), .SPOLL_VALID(pv), .CMD_DONE(cd),
      .MSS(mss), .SRQ(srq));
   task chk(input [63:0] n, input [7:0] e, input [7:0] s);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            failures = failures + 1;
            $display("unexpected %0s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task w(input integer n);
      repeat (n) @(negedge CLK);
   endtask
   task q(input [7:0] e);
      begin
         i_ctl.pulse(6'h10, 8'h00);
         chk("mask", e, sd);
      end
   endtask
   task wm(input [7:0] d);
      begin
         i_ctl.pulse(6'h20, d);
         w(2);
      end
   endtask
   task rst;
      begin
         NRST = 0;
         w(4);
         NRST = 1;
         w(5);
      end
   endtask
   task s_write;
      begin
         q(8'h00);
         i_ctl.pulse(6'h20, 8'h8C);
         chk("done", 8'h01, {7'h00, cd});
         wm(8'h18);
         q(8'h18);
      end
   endtask
   task s_sum;
      begin
         stb = 8'h08;
         w(2);
         chk("mss", 8'h01, {7'h00, mss});
         chk("srq", 8'h01, {7'h00, srq});
         stb = 8'h64;
         w(2);
         chk("mss", 8'h00, {7'h00, mss});
         wm(8'h60);
         chk("mss", 8'h00, {7'h00, mss});
         ev = 8'h01;
         en = 8'h01;
         w(2);
         chk("mss", 8'h01, {7'h00, mss});
      end
   endtask
   task s_poll;
      begin
         i_ctl.pulse(6'h08, 8'h00);
         chk("stb", 8'h64, td);
         chk("srq", 8'h01, {7'h00, srq});
         i_ctl.pulse(6'h02, 8'h00);
         chk("done", 8'h01, {7'h00, cd});
         i_ctl.pulse(6'h01, 8'h00);
         chk("srq", 8'h01, {7'h00, srq});
         i_ctl.pulse(6'h04, 8'h00);
         chk("poll", 8'h64, pd);
         chk("srq", 8'h00, {7'h00, srq});
         chk("mss", 8'h01, {7'h00, mss});
         q(8'h60);
      end
   endtask
   task s_zero;
      begin
         wm(8'h18);
         stb = 8'hFF;
         w(2);
         chk("srq", 8'h01, {7'h00, srq});
         wm(8'h00);
         chk("srq", 8'h00, {7'h00, srq});
         w(2);
         chk("srq", 8'h00, {7'h00, srq});
         wm(8'h18);
         PSC = 0;
         rst;
         q(8'h18);
         PSC = 1;
         rst;
         q(8'h00);
      end
   endtask
   task close_out;
      begin
         $display("failures %0d samples_checked %0d", failures, samples_checked);
         if (failures == 0 && samples_checked > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      w(4);
      NRST = 1;
      w(5);
      s_write;
      s_sum;
      s_poll;
      s_zero;
      close_out;
   end
   // whole run is under 200 cycles; the limit allows 1000
   initial begin
      #100000;
      failures = failures + 1;
      close_out;
   end
endmodule
